//--- verilog/ldd_decoder.sv
// Host I/O decoder routing cycles to logical devices and config port.
// Assumes a bus front end on clk presents one-cycle I/O requests; the
// strap input comes from a pin and is synchronised here.
`include "ldd_map.svh"
module ldd_decoder #(
   parameter int NUM_LDN = `LDD_NUM_LDN
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic config_address_strap,
   input wire ldd_pkg::ldd_io_req_s io_req,
   output ldd_pkg::ldd_sel_s sel,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid
);
   import ldd_pkg::*;

   logic strap_s1_r;
   logic strap_s2_r;
   logic strap_taken_r;
   logic [7:0] index_r;
   logic [7:0] ldn_r;
   logic [7:0] global_r;
   logic [7:0] cfg_a_r;
   logic [7:0] cfg_b_r;
   logic [15:0] base_r [NUM_LDN];
   ldd_sel_s sel_r;
   ldd_sel_s sel_nxt;
   logic [7:0] cfg_rdata_r;
   logic cfg_rvalid_r;

   wire logic [11:0] a12;
   wire logic upper_ok;
   wire logic [15:0] cfg_base;
   wire logic cfg_hit_idx;
   wire logic cfg_hit_dat;
   wire logic dat_wr;
   wire logic dat_rd;
   wire logic [7:0] cfg_rd_val;

   // Pin strap passes two flops; only the second feeds the config logic
   always_ff @(posedge clk) begin
      strap_s1_r <= config_address_strap;
      strap_s2_r <= strap_s1_r;
   end

   // Address qualification
   assign a12 = io_req.addr[11:0];
   assign upper_ok = !global_r[`LDD_GLOBAL_Q16_BIT] ||
      (io_req.addr[15:12] == 4'h0);

   // Config port location from registers 26/27
   assign cfg_base = {cfg_b_r, cfg_a_r[7:1], 1'b0};
   assign cfg_hit_idx = io_req.valid &&
      (io_req.addr == cfg_base);
   assign cfg_hit_dat = io_req.valid &&
      (io_req.addr == cfg_base + 16'h0001);
   assign dat_wr = cfg_hit_dat && io_req.write;
   assign dat_rd = cfg_hit_dat && !io_req.write;

   // Index compare shared by every config write strobe except wr_index
   function automatic logic at_index(input logic [7:0] cur,
      input logic [7:0] want);
      return cur == want;
   endfunction : at_index

   // One strobe per register keeps the flop processes short
   wire logic wr_index;
   wire logic wr_cfg_a;
   wire logic wr_cfg_b;
   wire logic wr_global;
   wire logic wr_ldn;
   wire logic wr_base_hi;
   wire logic wr_base_lo;
   assign wr_index = cfg_hit_idx && io_req.write;
   assign wr_cfg_a = dat_wr && at_index(index_r, `LDD_IDX_CFG_A);
   assign wr_cfg_b = dat_wr && at_index(index_r, `LDD_IDX_CFG_B);
   assign wr_global = dat_wr && at_index(index_r, `LDD_IDX_GLOBAL);
   assign wr_ldn = dat_wr && at_index(index_r, `LDD_IDX_LDN);
   assign wr_base_hi = dat_wr && at_index(index_r, `LDD_IDX_BASE_HI);
   assign wr_base_lo = dat_wr && at_index(index_r, `LDD_IDX_BASE_LO);

   // Per-device comparators
   wire logic [11:0] b_fdc, b_pp, b_sp1, b_sp2, b_game, b_rt, b_midi;
   assign b_fdc = base_r[`LDD_LDN_FDC][11:0];
   assign b_pp = base_r[`LDD_LDN_PP][11:0];
   assign b_sp1 = base_r[`LDD_LDN_SP1][11:0];
   assign b_sp2 = base_r[`LDD_LDN_SP2][11:0];
   assign b_game = base_r[`LDD_LDN_GAME][11:0];
   assign b_rt = base_r[`LDD_LDN_RT][11:0];
   assign b_midi = base_r[`LDD_LDN_MIDI][11:0];

   wire logic h_fdc, h_pp4, h_sp1, h_sp2, h_game, h_rt, h_midi;
   wire logic ok_pp4, ok_pp8, h_pp8, h_ecp;
   wire logic [6:0] o_fdc, o_pp, o_sp1, o_sp2, o_game, o_rt, o_midi;
   wire logic [6:0] o_ecp;

   ldd_match #(.ALIGN_BITS(3), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_8)) u_fdc (.base(b_fdc), .addr(a12),
      .base_ok(), .hit(h_fdc), .offset(o_fdc));
   ldd_match #(.ALIGN_BITS(2), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_4)) u_pp4 (.base(b_pp), .addr(a12),
      .base_ok(ok_pp4), .hit(h_pp4), .offset(o_pp));
   ldd_match #(.ALIGN_BITS(3), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_8)) u_pp8 (.base(b_pp), .addr(a12),
      .base_ok(ok_pp8), .hit(h_pp8), .offset());
   ldd_match #(.ALIGN_BITS(2), .RANGE_LO(`LDD_RANGE_LO + `LDD_ECP_OFS),
      .RANGE_HI(`LDD_RANGE_HI_1)) u_ecp (
      .base(b_pp + `LDD_ECP_OFS), .addr(a12),
      .base_ok(), .hit(h_ecp), .offset(o_ecp));
   ldd_match #(.ALIGN_BITS(3), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_8)) u_sp1 (.base(b_sp1), .addr(a12),
      .base_ok(), .hit(h_sp1), .offset(o_sp1));
   ldd_match #(.ALIGN_BITS(3), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_8)) u_sp2 (.base(b_sp2), .addr(a12),
      .base_ok(), .hit(h_sp2), .offset(o_sp2));
   ldd_match #(.ALIGN_BITS(0), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_1)) u_game (.base(b_game), .addr(a12),
      .base_ok(), .hit(h_game), .offset(o_game));
   ldd_match #(.ALIGN_BITS(7), .RANGE_LO(`LDD_RT_RANGE_LO),
      .RANGE_HI(`LDD_RT_RANGE_HI)) u_rt (.base(b_rt), .addr(a12),
      .base_ok(), .hit(h_rt), .offset(o_rt));
   ldd_match #(.ALIGN_BITS(1), .RANGE_LO(`LDD_RANGE_LO),
      .RANGE_HI(`LDD_RANGE_HI_2)) u_midi (.base(b_midi), .addr(a12),
      .base_ok(), .hit(h_midi), .offset(o_midi));

   // Parallel port split: low three via 4-byte match, EPP only if 8-aligned
   // ECP block answers only while the 4-byte base itself is legal
   wire logic pp_low;
   wire logic pp_epp;
   wire logic ecp_ok;
   wire logic fdc_ok;
   assign pp_low = h_pp4 && (o_pp[1:0] != 2'h3);
   assign pp_epp = ok_pp8 && h_pp8 &&
      (o_pp[2:0] >= `LDD_EPP_FIRST);
   assign ecp_ok = ok_pp4 && h_ecp &&
      ({5'h0, o_ecp} <= (`LDD_ECP_LAST - `LDD_ECP_OFS));
   assign fdc_ok = h_fdc && (o_fdc[2:0] != `LDD_FDC_HOLE);

   // Priority: config port, keyboard, then relocatable devices
   always_comb begin
      sel_nxt = '0;
      sel_nxt.write = io_req.write;
      sel_nxt.wdata = io_req.wdata;
      if (!io_req.valid) begin
         sel_nxt.hit = 1'b0;
      end else if (cfg_hit_idx || cfg_hit_dat) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_CFG;
         sel_nxt.offset = {6'h0, cfg_hit_dat};
      end else if (!upper_ok) begin
         sel_nxt.hit = 1'b0;
      end else if (a12 == `LDD_KBD_DATA || a12 == `LDD_KBD_CMD) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_KBD;
         sel_nxt.offset = {4'h0, a12[2:0]};
      end else if (fdc_ok) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_FDC;
         sel_nxt.offset = o_fdc;
      end else if (pp_epp) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_PP_EPP;
         sel_nxt.offset = o_pp;
      end else if (pp_low) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_PP;
         sel_nxt.offset = {5'h0, o_pp[1:0]};
      end else if (ecp_ok) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_PP_ECP;
         sel_nxt.offset = o_ecp;
      end else if (h_sp1) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_SP1;
         sel_nxt.offset = o_sp1;
      end else if (h_sp2) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_SP2;
         sel_nxt.offset = o_sp2;
      end else if (h_game) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_GAME;
         sel_nxt.offset = o_game;
      end else if (h_rt) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_RT;
         sel_nxt.offset = o_rt;
      end else if (h_midi) begin
         sel_nxt.hit = 1'b1;
         sel_nxt.tgt = LDD_TGT_MIDI;
         sel_nxt.offset = o_midi;
      end else begin
         sel_nxt.hit = 1'b0;
      end
   end

   // Config data readback mux
   wire logic [3:0] ldn4;
   wire logic ldn_valid;
   assign ldn4 = ldn_r[3:0];
   assign ldn_valid = ldn_r < 8'(NUM_LDN);
   assign cfg_rd_val =
      (index_r == `LDD_IDX_CFG_A) ? cfg_a_r :
      (index_r == `LDD_IDX_CFG_B) ? cfg_b_r :
      (index_r == `LDD_IDX_GLOBAL) ? global_r :
      (index_r == `LDD_IDX_LDN) ? ldn_r :
      (index_r == `LDD_IDX_BASE_HI && ldn_valid) ? base_r[ldn4][15:8] :
      (index_r == `LDD_IDX_BASE_LO && ldn_valid) ? base_r[ldn4][7:0] :
      8'h00;

   // Config registers; the strap is caught one cycle after reset release
   // because an async-style reset load from a pin is not allowed
   // The strap load wins over a write to 26 landing on that same edge
   always_ff @(posedge clk) begin
      if (srst) begin
         strap_taken_r <= 1'b0;
         index_r <= 8'h00;
         ldn_r <= 8'h00;
         global_r <= 8'h00;
         cfg_a_r <= 8'(`LDD_CFG_PORT_S0);
         cfg_b_r <= 8'h00;
      end else begin
         if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            cfg_a_r <= strap_s2_r ? 8'(`LDD_CFG_PORT_S1) :
               8'(`LDD_CFG_PORT_S0);
         end else if (wr_cfg_a) begin
            cfg_a_r <= io_req.wdata;
         end
         if (wr_index) begin
            index_r <= io_req.wdata;
         end
         if (wr_cfg_b) begin
            cfg_b_r <= io_req.wdata;
         end
         if (wr_global) begin
            global_r <= io_req.wdata;
         end
         if (wr_ldn) begin
            ldn_r <= io_req.wdata;
         end
      end
   end

   // Per-device base registers, zero at reset
   // Upper byte is stored whole; only bits 11..0 enter the compare
   generate
      for (genvar i = 0; i < NUM_LDN; i++) begin : g_base
         always_ff @(posedge clk) begin
            if (srst) begin
               base_r[i] <= 16'h0000;
            end else if (dat_wr && ldn_r == 8'(i)) begin
               if (wr_base_hi) begin
                  base_r[i][15:8] <= io_req.wdata;
               end else if (wr_base_lo) begin
                  base_r[i][7:0] <= io_req.wdata;
               end
            end
         end
      end
   endgenerate

   // Registered outputs: decode and read data one cycle after request
   // Costs a cycle of latency but gives devices a glitch-free select
   always_ff @(posedge clk) begin
      if (srst) begin
         sel_r <= '0;
         cfg_rdata_r <= 8'h00;
         cfg_rvalid_r <= 1'b0;
      end else begin
         sel_r <= sel_nxt;
         cfg_rvalid_r <= dat_rd || (cfg_hit_idx && !io_req.write);
         cfg_rdata_r <= dat_rd ? cfg_rd_val : index_r;
      end
   end

   assign sel = sel_r;
   assign cfg_rdata = cfg_rdata_r;
   assign cfg_rvalid = cfg_rvalid_r;
endmodule : ldd_decoder

//--- shared/ldd_map.svh
// Address map constants for the logical device I/O decoder.
// Assumes inclusion by the package and by design files; definitions only.
`ifndef LDD_MAP_SVH
`define LDD_MAP_SVH
`define LDD_IDX_CFG_A      8'h26
`define LDD_IDX_CFG_B      8'h27
`define LDD_IDX_GLOBAL     8'h24
`define LDD_IDX_LDN        8'h07
`define LDD_IDX_BASE_HI    8'h60
`define LDD_IDX_BASE_LO    8'h61
`define LDD_GLOBAL_Q16_BIT 6
`define LDD_CFG_PORT_S0    16'h002e
`define LDD_CFG_PORT_S1    16'h004e
`define LDD_KBD_DATA       12'h060
`define LDD_KBD_CMD        12'h064
`define LDD_RANGE_LO       12'h100
`define LDD_RANGE_HI_8     12'hff8
`define LDD_RANGE_HI_4     12'hffc
`define LDD_RANGE_HI_2     12'hffe
`define LDD_RANGE_HI_1     12'hfff
`define LDD_RT_RANGE_LO    12'h000
`define LDD_RT_RANGE_HI    12'hf7f
`define LDD_ECP_OFS        12'h400
`define LDD_ECP_LAST       12'h402
`define LDD_EPP_FIRST      3'h3
`define LDD_FDC_HOLE       3'h6
`define LDD_LDN_FDC        4'h0
`define LDD_LDN_PP         4'h3
`define LDD_LDN_SP1        4'h4
`define LDD_LDN_SP2        4'h5
`define LDD_LDN_GAME       4'h9
`define LDD_LDN_RT         4'ha
`define LDD_LDN_MIDI       4'hb
`define LDD_NUM_LDN        12
`endif

//--- shared/ldd_pkg.sv
// Types for the logical device I/O decoder.
// Assumes ldd_map.svh is on the include path.
`include "ldd_map.svh"
package ldd_pkg;
   // Host I/O cycle as presented by the bus front end
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [7:0] wdata;
   } ldd_io_req_s;

   // Decoded target: which device, and the offset within it
   typedef enum logic [3:0] {
      LDD_TGT_NONE = 4'h0,
      LDD_TGT_FDC = 4'h1,
      LDD_TGT_PP = 4'h2,
      LDD_TGT_PP_EPP = 4'h3,
      LDD_TGT_PP_ECP = 4'h4,
      LDD_TGT_SP1 = 4'h5,
      LDD_TGT_SP2 = 4'h6,
      LDD_TGT_KBD = 4'h7,
      LDD_TGT_GAME = 4'h8,
      LDD_TGT_RT = 4'h9,
      LDD_TGT_MIDI = 4'ha,
      LDD_TGT_CFG = 4'hb
   } ldd_tgt_e;

   typedef struct packed {
      logic hit;
      ldd_tgt_e tgt;
      logic [6:0] offset;
      logic write;
      logic [7:0] wdata;
   } ldd_sel_s;
endpackage : ldd_pkg

//--- verilog/ldd_match.sv
// One logical device base comparator with range and alignment checks.
// Assumes base and address are 12-bit I/O addresses on the same clock.
module ldd_match #(
   parameter int ALIGN_BITS = 3,
   parameter logic [11:0] RANGE_LO = 12'h100,
   parameter logic [11:0] RANGE_HI = 12'hff8
) (
   input wire logic [11:0] base,
   input wire logic [11:0] addr,
   output logic base_ok,
   output logic hit,
   output logic [6:0] offset
);
   wire logic in_range;
   wire logic aligned;
   wire logic [11:0] diff;

   // Base must sit in range and on its boundary, else device is dead
   assign in_range = (base >= RANGE_LO) && (base <= RANGE_HI);
   generate
      if (ALIGN_BITS == 0) begin : g_noalign
         assign aligned = 1'b1;
         assign hit = base_ok && (addr == base);
      end else begin : g_align
         assign aligned = (base[ALIGN_BITS-1:0] == '0);
         assign hit = base_ok &&
            (addr[11:ALIGN_BITS] == base[11:ALIGN_BITS]);
      end
   endgenerate
   assign base_ok = in_range && aligned;
   assign diff = addr - base;
   assign offset = diff[6:0];
endmodule : ldd_match

//--- dv/ldd_decoder_properties.sv
// Port checker for the logical device I/O decoder.
// Assumes binding to ldd_decoder; sees only its ports.
`include "ldd_map.svh"
module ldd_decoder_properties #(
   parameter int NUM_LDN = `LDD_NUM_LDN
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic config_address_strap,
   input wire ldd_pkg::ldd_io_req_s io_req,
   input wire ldd_pkg::ldd_sel_s sel,
   input wire logic [7:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   import ldd_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Reset must leave the outputs quiet one edge later too
   a_reset_quiet: assert property (disable iff (1'b0)
      srst |=> !sel.hit && !cfg_rvalid) else $error("output after reset");
   a_idle_no_hit: assert property (!io_req.valid |=> !sel.hit)
      else $error("hit without request");
   a_kbd_data: assert property (io_req.valid &&
      io_req.addr == 16'h0060
      |=> sel.hit && sel.tgt == LDD_TGT_KBD && sel.offset == 7'h00)
      else $error("keyboard data missed");
   a_kbd_cmd: assert property (io_req.valid &&
      io_req.addr == 16'h0064
      |=> sel.hit && sel.tgt == LDD_TGT_KBD && sel.offset == 7'h04)
      else $error("keyboard command missed");
   a_fdc_offsets: assert property (sel.hit && sel.tgt == LDD_TGT_FDC
      |-> sel.offset != 7'h06 && sel.offset == $past(io_req.addr[2:0]))
      else $error("floppy offset wrong");
   a_sp_offsets: assert property (sel.hit && sel.tgt inside
      {LDD_TGT_SP1, LDD_TGT_SP2} |-> sel.offset == $past(io_req.addr[2:0]))
      else $error("serial offset wrong");
   a_epp_window: assert property (sel.hit && sel.tgt == LDD_TGT_PP_EPP
      |-> sel.offset inside {[3:7]}) else $error("epp offset wrong");
   a_pp_std: assert property (sel.hit && sel.tgt inside
      {LDD_TGT_PP, LDD_TGT_PP_ECP} |-> sel.offset <= 7'h02)
      else $error("parallel offset wrong");
   a_rt_offset: assert property (sel.hit && sel.tgt == LDD_TGT_RT
      |-> sel.offset == $past(io_req.addr[6:0])) else $error("runtime ofs");
   a_cfg_read: assert property (cfg_rvalid ==
      (sel.hit && sel.tgt == LDD_TGT_CFG && !sel.write))
      else $error("config read strobe wrong");
   a_write_follow: assert property (sel.hit |->
      sel.write == $past(io_req.write) && sel.wdata == $past(io_req.wdata))
      else $error("write data not carried");
endmodule : ldd_decoder_properties

//--- dv/ldd_host_model.sv
// Host bridge model issuing one-cycle I/O requests.
// Assumes its tasks are entered at a falling clock edge.
module ldd_host_model (
   input wire logic clk,
   output ldd_pkg::ldd_io_req_s io_req
);
   timeunit 1ns;
   timeprecision 1ps;
   import ldd_pkg::*;
   logic q16_r = 1'b0; // Host knows upper bits are checked
   initial io_req = '0;
   // Held to the next falling edge; upper nibble zeroed while q16_r is set, unless breach
   task automatic put(input logic wr, input logic [15:0] a,
                      input logic [7:0] d, input logic breach);
      io_req <= '{1'b1, wr,
         (q16_r && !breach) ? {4'h0, a[11:0]} : a, d};
      @(negedge clk);
   endtask : put
   task automatic idle();
      io_req.valid <= 1'b0;
   endtask : idle
endmodule : ldd_host_model

//--- dv/tb_top.sv
// Bench for the logical device I/O decoder: config and decode checks.
// Assumes the package, decoder, host model and checker are compiled.
`include "ldd_map.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ldd_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic strap = 1'b1;
   ldd_io_req_s io_req;
   ldd_sel_s sel;
   logic [7:0] cfg_rdata;
   logic cfg_rvalid;
   int err_count = 0;
   int comparisons = 0;
   logic [15:0] cfg_port = `LDD_CFG_PORT_S1;

   initial begin
      forever #2.5 clk = ~clk;
   end
   ldd_host_model ldd_host_model_i (.clk(clk), .io_req(io_req));
   ldd_decoder ldd_decoder_i (.clk(clk), .srst(srst),
      .config_address_strap(strap), .io_req(io_req), .sel(sel),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // Misses compare the hit flag only; target is don't-care then
   task automatic io(input logic [15:0] a, input logic h,
                     input ldd_tgt_e t, input logic [6:0] o);
      ldd_host_model_i.put(1'b0, a, 8'h00, 1'b1);
      chk(h ? {sel.hit, sel.tgt, sel.offset} : {sel.hit, 11'h0},
         h ? {h, t, o} : 12'h0);
   endtask : io
   task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] v);
      ldd_host_model_i.put(1'b1, cfg_port, idx, 1'b0);
      chk({sel.hit, sel.tgt, sel.offset}, {1'b1, LDD_TGT_CFG, 7'h0});
      ldd_host_model_i.put(1'b1, cfg_port + 16'h1, v, 1'b0);
   endtask : cfg_wr
   task automatic cfg_rd(input logic [7:0] idx, input logic [7:0] exp);
      ldd_host_model_i.put(1'b1, cfg_port, idx, 1'b0);
      ldd_host_model_i.put(1'b0, cfg_port + 16'h1, 8'h00, 1'b0);
      chk({3'h0, cfg_rvalid, cfg_rdata}, {3'h0, 1'b1, exp});
   endtask : cfg_rd
   task automatic set_base(input logic [7:0] ldn, input logic [15:0] b);
      cfg_wr(`LDD_IDX_LDN, ldn);
      cfg_wr(`LDD_IDX_BASE_HI, b[15:8]);
      cfg_wr(`LDD_IDX_BASE_LO, b[7:0]);
   endtask : set_base

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      close_out();
   end
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      // Strap high: 2E is no config port, runtime block at base 0 owns it
      io(16'h002e, 1'b1, LDD_TGT_RT, 7'h2e);
      cfg_wr(`LDD_IDX_LDN, 8'h00);
      cfg_rd(8'h60, 8'h00);
      cfg_rd(8'h61, 8'h00);
      io(16'h0003, 1'b1, LDD_TGT_RT, 7'h03);
      set_base(`LDD_LDN_FDC, 16'h03f0);
      set_base(`LDD_LDN_PP, 16'h0378);
      set_base(`LDD_LDN_SP1, 16'h03f8);
      set_base(`LDD_LDN_SP2, 16'h02f8);
      set_base(`LDD_LDN_GAME, 16'h0201);
      set_base(`LDD_LDN_RT, 16'h0800);
      set_base(`LDD_LDN_MIDI, 16'h0330);
      cfg_rd(8'h61, 8'h30);
      for (int i = 0; i < 8; i++) begin
         io(16'h03f0 + 16'(i), i != 6, LDD_TGT_FDC, 7'(i));
         io(16'h0378 + 16'(i), 1'b1,
            i < 3 ? LDD_TGT_PP : LDD_TGT_PP_EPP, 7'(i));
         io(16'h03f8 + 16'(i), 1'b1, LDD_TGT_SP1, 7'(i));
         io(16'h02f8 + 16'(i), 1'b1, LDD_TGT_SP2, 7'(i));
         if (i < 3) begin
            io(16'h0778 + 16'(i), 1'b1, LDD_TGT_PP_ECP, 7'(i));
            io(16'h0330 + 16'(i), i < 2, LDD_TGT_MIDI, 7'(i));
         end
      end
      io(16'h0060, 1'b1, LDD_TGT_KBD, 7'h00);
      io(16'h0064, 1'b1, LDD_TGT_KBD, 7'h04);
      io(16'h0201, 1'b1, LDD_TGT_GAME, 7'h00);
      io(16'h0202, 1'b0, LDD_TGT_NONE, 7'h00);
      io(16'h085f, 1'b1, LDD_TGT_RT, 7'h5f);
      set_base(`LDD_LDN_PP, 16'h027c);
      io(16'h027c, 1'b1, LDD_TGT_PP, 7'h00);
      io(16'h027f, 1'b0, LDD_TGT_NONE, 7'h00);
      set_base(`LDD_LDN_FDC, 16'h03f4);
      io(16'h03f4, 1'b0, LDD_TGT_NONE, 7'h00);
      set_base(`LDD_LDN_RT, 16'h0f80);
      io(16'h0f80, 1'b0, LDD_TGT_NONE, 7'h00);
      // Upper nibble set on purpose while qualification is on
      cfg_wr(`LDD_IDX_GLOBAL, 8'h40);
      ldd_host_model_i.q16_r = 1'b1;
      io(16'h1330, 1'b0, LDD_TGT_NONE, 7'h00);
      io(16'h0331, 1'b1, LDD_TGT_MIDI, 7'h01);
      cfg_wr(`LDD_IDX_GLOBAL, 8'h00);
      ldd_host_model_i.q16_r = 1'b0;
      io(16'h1330, 1'b1, LDD_TGT_MIDI, 7'h00);
      // Move the port in two steps; bit 0 of the low byte is ignored
      cfg_wr(`LDD_IDX_CFG_B, 8'h05);
      cfg_port = 16'h054e;
      cfg_wr(`LDD_IDX_CFG_A, 8'h71);
      cfg_port = 16'h0570;
      io(16'h004e, 1'b0, LDD_TGT_NONE, 7'h00);
      cfg_rd(`LDD_IDX_CFG_A, 8'h71);
      cfg_rd(`LDD_IDX_CFG_B, 8'h05);
      // Second reset with the strap low: port returns to its other home
      ldd_host_model_i.idle();
      strap = 1'b0;
      srst = 1'b1;
      repeat (4) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      cfg_port = `LDD_CFG_PORT_S0;
      cfg_rd(`LDD_IDX_CFG_A, 8'h2e);
      cfg_rd(`LDD_IDX_CFG_B, 8'h00);
      cfg_rd(8'h60, 8'h00);
      io(16'h0330, 1'b0, LDD_TGT_NONE, 7'h00);
      ldd_host_model_i.idle();
      @(negedge clk);
      close_out();
   end
endmodule : tb_top

bind ldd_decoder ldd_decoder_properties #(.NUM_LDN(NUM_LDN))
   ldd_decoder_properties_i (.clk(clk), .srst(srst),
   .config_address_strap(config_address_strap), .io_req(io_req),
   .sel(sel), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
